/* File: logic/oic_device.sv */
`include "oic_defs.svh"
`default_nettype none
module oic_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   wire logic do_wr = in_valid & in_ready;
   wire logic do_rd = out_valid & out_ready;
   assign in_ready = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) | (wr_ptr[AW] == rd_ptr[AW]);
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data = mem[rd_ptr[AW-1:0]];
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= wr_ptr + (AW+1)'(do_wr);
         rd_ptr <= rd_ptr + (AW+1)'(do_rd);
      end
   end
endmodule
////////////////////////////////////////////////////////////////////////////////
module oic_device #(
   parameter int FIFO_DEPTH = 4
) (
   // clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // serial link
   oic_if.device LINK,
   // straps and flow
   input wire logic ADDR_SELECT_BIT,
   input wire logic DRAIN_HOLD,
   // display RAM readback
   input wire logic [9:0] RD_ADDR,
   output logic [7:0] RD_DATA,
   // decoded settings
   output logic [7:0] CONTRAST,
   output logic [7:0] MUX_RATIO,
   output logic [7:0] DISP_OFFSET,
   output logic PUMP_ON,
   output logic REFERENCE_CURRENT_INT,
   output logic [7:0] COM_CFG,
   output logic DISPLAY_ON,
   output logic [6:0] COL_PTR,
   output logic [2:0] PAGE_PTR
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; stage 3 only feeds edge detection
   logic scl_s1, scl_s2, scl_s3;
   logic sda_s1, sda_s2, sda_s3;
   logic sel_s1, sel_s2;
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         {scl_s1, scl_s2, scl_s3} <= 3'h7;
         {sda_s1, sda_s2, sda_s3} <= 3'h7;
         {sel_s1, sel_s2} <= 2'h0;
      end else begin
         {scl_s1, scl_s2, scl_s3} <= {LINK.scl_line, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_s3} <= {LINK.sda_line, sda_s1, sda_s2};
         {sel_s1, sel_s2} <= {ADDR_SELECT_BIT, sel_s1};
      end
   end
   wire logic scl_rise = scl_s2 & ~scl_s3;
   wire logic scl_fall = ~scl_s2 & scl_s3;
   wire logic start_c = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   wire logic stop_c = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
   ////////////////////////////////////////////////////////////////////////////
   // byte receiver
   oic_pkg::oic_dev_state_e st, next_st;
   logic [7:0] shreg;
   logic [3:0] bit_cnt;
   logic in_ack;
   logic sda_oe;
   logic dc;
   logic stream;
   logic f_in_ready, f_out_valid;
   logic [8:0] f_out_data;
   wire logic byte_done = scl_fall & (bit_cnt == 4'h8) & ~in_ack;
   localparam logic [6:0] ADDR_BASE = `OIC_ADDR_BASE;
   wire logic addr_hit = shreg[7:1] == {ADDR_BASE[6:1], sel_s2};
   wire logic is_ctrl = shreg[5:0] == `OIC_CTRL_PAD;
   wire logic in_ctrl = st == oic_pkg::DS_CTRL;
   wire logic in_pay = st == oic_pkg::DS_PAY;
   // a byte where a control byte was due is taken as a command
   wire logic push = byte_done & (in_pay | (in_ctrl & ~is_ctrl));
   wire logic [8:0] push_data = {in_pay & dc, shreg};
   wire logic ack_now = byte_done & (((st == oic_pkg::DS_ADDR) & addr_hit) |
      (in_ctrl & is_ctrl) | (push & f_in_ready));
   always_comb begin
      next_st = st;
      if (start_c) begin
         next_st = oic_pkg::DS_ADDR;
      end else if (stop_c) begin
         next_st = oic_pkg::DS_IDLE;
      end else if (byte_done) begin
         case (st)
            oic_pkg::DS_ADDR: begin
               if (!addr_hit) begin
                  next_st = oic_pkg::DS_SKIP;
               end else if (shreg[0] == `OIC_RW_READ) begin
                  next_st = oic_pkg::DS_READ;
               end else begin
                  next_st = oic_pkg::DS_CTRL;
               end
            end
            oic_pkg::DS_CTRL: begin
               if (is_ctrl) begin
                  next_st = oic_pkg::DS_PAY;
               end else if (!f_in_ready) begin
                  next_st = oic_pkg::DS_SKIP;
               end
            end
            oic_pkg::DS_PAY: begin
               if (!f_in_ready) begin
                  next_st = oic_pkg::DS_SKIP;
               end else if (!stream) begin
                  next_st = oic_pkg::DS_CTRL;
               end
            end
            default: next_st = st;
         endcase
      end
   end
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         st <= oic_pkg::DS_IDLE;
         shreg <= 8'h00;
         bit_cnt <= 4'h0;
         in_ack <= 1'b0;
         sda_oe <= 1'b0;
         dc <= 1'b0;
         stream <= 1'b0;
      end else begin
         st <= next_st;
         if (start_c || stop_c) begin
            bit_cnt <= 4'h0;
            in_ack <= 1'b0;
            sda_oe <= 1'b0;
            stream <= 1'b0;
         end else if (byte_done) begin
            bit_cnt <= 4'h0;
            in_ack <= 1'b1;
            sda_oe <= ack_now;
         end else if (scl_fall && in_ack) begin
            in_ack <= 1'b0;
            sda_oe <= 1'b0;
         end else if (scl_rise && !in_ack && bit_cnt != 4'h8) begin
            shreg <= {shreg[6:0], sda_s2};
            bit_cnt <= bit_cnt + 4'h1;
         end
         if (byte_done && in_ctrl && is_ctrl) begin
            dc <= shreg[`OIC_CTRL_DC_BIT];
            stream <= ~shreg[`OIC_CTRL_CONT_BIT];
         end
      end
   end
   // read mode has no readback path: the line stays released and reads ones
   assign LINK.dev_sda_oe = sda_oe;
   ////////////////////////////////////////////////////////////////////////////
   // buffer between the link and the decoder; a full buffer answers not-ack
   wire logic pop = f_out_valid & ~DRAIN_HOLD;
   oic_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(CLK),
      .rst(SYS_RST),
      .in_valid(push),
      .in_ready(f_in_ready),
      .in_data(push_data),
      .out_valid(f_out_valid),
      .out_ready(~DRAIN_HOLD),
      .out_data(f_out_data)
   );
   ////////////////////////////////////////////////////////////////////////////
   // command decoder and display RAM
   logic [7:0] ram [0:1023];
   logic arg_wait;
   logic [7:0] arg_op;
   wire logic is_data = f_out_data[8];
   wire logic [7:0] b = f_out_data[7:0];
   wire logic two_byte = (b == `OIC_CMD_CONTRAST) | (b == `OIC_CMD_MUX) |
      (b == `OIC_CMD_OFFSET) | (b == `OIC_CMD_PUMP) | (b == `OIC_CMD_REFERENCE_CURRENT) |
      (b == `OIC_CMD_COMCFG) | (b == `OIC_CMD_CLKDIV) | (b == `OIC_CMD_PRECHG) |
      (b == `OIC_CMD_VCOMH);
   wire logic ram_we = pop & is_data;
   wire logic cmd_pop = pop & ~is_data;
   always_ff @(posedge CLK) begin
      if (ram_we) begin
         ram[{PAGE_PTR, COL_PTR}] <= b;
      end
      RD_DATA <= ram[RD_ADDR];
   end
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         CONTRAST <= `OIC_CONTRAST_RST;
         MUX_RATIO <= `OIC_MUX_RST;
         DISP_OFFSET <= `OIC_OFFSET_RST;
         PUMP_ON <= 1'b0;
         REFERENCE_CURRENT_INT <= 1'b0;
         COM_CFG <= `OIC_COMCFG_RST;
         DISPLAY_ON <= 1'b0;
         COL_PTR <= 7'h00;
         PAGE_PTR <= 3'h0;
         arg_wait <= 1'b0;
         arg_op <= 8'h00;
      end else if (ram_we) begin
         COL_PTR <= COL_PTR + 7'h01;
      end else if (cmd_pop && arg_wait) begin
         arg_wait <= 1'b0;
         case (arg_op)
            `OIC_CMD_CONTRAST: CONTRAST <= b;
            `OIC_CMD_MUX: MUX_RATIO <= b;
            `OIC_CMD_OFFSET: DISP_OFFSET <= b;
            `OIC_CMD_PUMP: begin
               if (b == `OIC_ARG_PUMP_ON) PUMP_ON <= 1'b1;
               else if (b == `OIC_ARG_PUMP_OFF) PUMP_ON <= 1'b0;
            end
            `OIC_CMD_REFERENCE_CURRENT: begin
               if (b == `OIC_ARG_REFERENCE_CURRENT_ON) REFERENCE_CURRENT_INT <= 1'b1;
               else if (b == `OIC_ARG_REFERENCE_CURRENT_OFF) REFERENCE_CURRENT_INT <= 1'b0;
            end
            `OIC_CMD_COMCFG: COM_CFG <= b;
            default: arg_wait <= 1'b0;
         endcase
      end else if (cmd_pop) begin
         if (two_byte) begin
            arg_wait <= 1'b1;
            arg_op <= b;
         end else if (b == `OIC_CMD_DISP_ON) begin
            DISPLAY_ON <= 1'b1;
         end else if (b == `OIC_CMD_DISP_OFF) begin
            DISPLAY_ON <= 1'b0;
         end else if (b[7:3] == `OIC_CMD_PAGE_HI) begin
            PAGE_PTR <= b[2:0];
         end
      end
   end
endmodule
`default_nettype wire

/* File: include/oic_defs.svh */
`ifndef OIC_DEFS_SVH
`define OIC_DEFS_SVH
// link addressing and control byte layout
`define OIC_ADDR_BASE 7'h3C
`define OIC_CTRL_PAD 6'h00
`define OIC_CTRL_CONT_BIT 7
`define OIC_CTRL_DC_BIT 6
`define OIC_RW_READ 1'h1
// command codes
`define OIC_CMD_CONTRAST 8'h81
`define OIC_CMD_MUX 8'hA8
`define OIC_CMD_OFFSET 8'hD3
`define OIC_CMD_PUMP 8'h8D
`define OIC_CMD_REFERENCE_CURRENT 8'hAD
`define OIC_CMD_COMCFG 8'hDA
`define OIC_CMD_CLKDIV 8'hD5
`define OIC_CMD_PRECHG 8'hD9
`define OIC_CMD_VCOMH 8'hDB
`define OIC_CMD_DISP_OFF 8'hAE
`define OIC_CMD_DISP_ON 8'hAF
`define OIC_CMD_PAGE_HI 5'h16
`define OIC_ARG_PUMP_ON 8'h14
`define OIC_ARG_PUMP_OFF 8'h10
`define OIC_ARG_REFERENCE_CURRENT_ON 8'h30
`define OIC_ARG_REFERENCE_CURRENT_OFF 8'h20
// reset values
`define OIC_CONTRAST_RST 8'h7F
`define OIC_MUX_RST 8'h3F
`define OIC_OFFSET_RST 8'h00
`define OIC_COMCFG_RST 8'h12
// host register map and command field
`define OIC_REG_CMD 4'h0
`define OIC_REG_TXDATA 4'h4
`define OIC_REG_STATUS 4'h8
`define OIC_OP_START 2'h0
`define OIC_OP_WRITE 2'h1
`define OIC_OP_STOP 2'h2
`define OIC_CMD_SA_BIT 2
`define OIC_CMD_RW_BIT 3
// timing
`define OIC_CLK_PERIOD_NS 25
`define OIC_SCL_PERIOD_NS 10000
`define OIC_SCL_QUARTER_CYC \
   ((`OIC_SCL_PERIOD_NS / 4 + `OIC_CLK_PERIOD_NS - 1) / `OIC_CLK_PERIOD_NS)
`endif

/* File: include/oic_pkg.sv */
`default_nettype none
package oic_pkg;
   typedef enum logic [5:0] {
      DS_IDLE = 6'h01,
      DS_ADDR = 6'h02,
      DS_CTRL = 6'h04,
      DS_PAY = 6'h08,
      DS_READ = 6'h10,
      DS_SKIP = 6'h20
   } oic_dev_state_e;
   typedef enum logic [4:0] {
      HS_IDLE = 5'h01,
      HS_START = 5'h02,
      HS_BIT = 5'h04,
      HS_ACK = 5'h08,
      HS_STOP = 5'h10
   } oic_host_state_e;
endpackage
`default_nettype wire

/* File: include/oic_if.sv */
`default_nettype none
interface oic_if;
   logic scl_oe;
   logic host_sda_oe;
   logic dev_sda_oe;
   logic scl_line;
   logic sda_line;
   // open-drain wired-and with pull-ups
   assign scl_line = ~scl_oe;
   assign sda_line = ~(host_sda_oe | dev_sda_oe);
   modport device (input scl_line, input sda_line, output dev_sda_oe);
   modport host (input sda_line, output scl_oe, output host_sda_oe);
endinterface
`default_nettype wire

/* File: logic/oic_host.sv */
`include "oic_defs.svh"
`default_nettype none
module oic_host #(
   parameter int QUARTER_CYC = `OIC_SCL_QUARTER_CYC
) (
   // clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // register port
   input wire logic [3:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // serial link
   oic_if.host LINK
);
   ////////////////////////////////////////////////////////////////////////////
   oic_pkg::oic_host_state_e st;
   logic [7:0] txdata;
   logic [7:0] sh;
   logic [2:0] bit_idx;
   logic [1:0] phase;
   logic [15:0] div;
   logic scl_oe, sda_oe, nack;
   logic sda_s1, sda_s2;
   wire logic busy = st != oic_pkg::HS_IDLE;
   wire logic tick = div == 16'(QUARTER_CYC - 1);
   wire logic cmd_wr = WR & (ADDR == `OIC_REG_CMD) & ~busy;
   wire logic [1:0] op = WDATA[1:0];
   localparam logic [6:0] ADDR_BASE = `OIC_ADDR_BASE;
   wire logic [7:0] addr_byte = {ADDR_BASE[6:1], WDATA[`OIC_CMD_SA_BIT],
      WDATA[`OIC_CMD_RW_BIT]};
   wire logic [31:0] rd_mux = (ADDR == `OIC_REG_TXDATA) ? {24'h000000, txdata} :
      (ADDR == `OIC_REG_STATUS) ? {30'h0, nack, busy} : 32'h00000000;
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         RDATA <= 32'h00000000;
         txdata <= 8'h00;
         {sda_s1, sda_s2} <= 2'h3;
      end else begin
         RDATA <= RD ? rd_mux : 32'h00000000;
         {sda_s1, sda_s2} <= {LINK.sda_line, sda_s1};
         if (WR && ADDR == `OIC_REG_TXDATA) begin
            txdata <= WDATA[7:0];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // bit engine: four quarter periods per bit, clock held low between bytes
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         st <= oic_pkg::HS_IDLE;
         div <= 16'h0000;
         phase <= 2'h0;
         bit_idx <= 3'h0;
         sh <= 8'h00;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         nack <= 1'b0;
      end else if (cmd_wr) begin
         div <= 16'h0000;
         phase <= 2'h0;
         bit_idx <= 3'h7;
         sh <= (op == `OIC_OP_START) ? addr_byte : txdata;
         if (op == `OIC_OP_START) st <= oic_pkg::HS_START;
         else if (op == `OIC_OP_WRITE) st <= oic_pkg::HS_BIT;
         else if (op == `OIC_OP_STOP) st <= oic_pkg::HS_STOP;
      end else if (busy) begin
         div <= tick ? 16'h0000 : div + 16'h0001;
         if (tick) begin
            phase <= phase + 2'h1;
            case (st)
               oic_pkg::HS_START: begin
                  if (phase == 2'h0) {scl_oe, sda_oe} <= 2'h0;
                  if (phase == 2'h1) sda_oe <= 1'b1;
                  if (phase == 2'h2) scl_oe <= 1'b1;
                  if (phase == 2'h3) st <= oic_pkg::HS_BIT;
               end
               oic_pkg::HS_BIT: begin
                  if (phase == 2'h0) sda_oe <= ~sh[bit_idx];
                  if (phase == 2'h1) scl_oe <= 1'b0;
                  if (phase == 2'h3) begin
                     scl_oe <= 1'b1;
                     bit_idx <= bit_idx - 3'h1;
                     // free data with the last clock fall so the ack never meets our drive
                     if (bit_idx == 3'h0) begin
                        st <= oic_pkg::HS_ACK;
                        sda_oe <= 1'b0;
                     end
                  end
               end
               oic_pkg::HS_ACK: begin
                  if (phase == 2'h0) sda_oe <= 1'b0;
                  if (phase == 2'h1) scl_oe <= 1'b0;
                  if (phase == 2'h2) nack <= sda_s2;
                  if (phase == 2'h3) begin
                     scl_oe <= 1'b1;
                     st <= oic_pkg::HS_IDLE;
                  end
               end
               oic_pkg::HS_STOP: begin
                  if (phase == 2'h0) sda_oe <= 1'b1;
                  if (phase == 2'h1) scl_oe <= 1'b0;
                  if (phase == 2'h2) sda_oe <= 1'b0;
                  if (phase == 2'h3) st <= oic_pkg::HS_IDLE;
               end
               default: st <= oic_pkg::HS_IDLE;
            endcase
         end
      end
   end
   assign LINK.scl_oe = scl_oe;
   assign LINK.host_sda_oe = sda_oe;
endmodule
`default_nettype wire

/* File: sim/oic_link_properties.sv */
`default_nettype none
module oic_link_properties (
   // clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // link lines
   input wire logic scl_oe,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe,
   input wire logic scl_line,
   input wire logic sda_line
);
   logic sda_q, scl_q, in_frame, start_seen, stop_seen, scl_rise;
   logic [3:0] bit_cnt;
   assign start_seen = scl_line & scl_q & sda_q & ~sda_line;
   assign stop_seen = scl_line & scl_q & ~sda_q & sda_line;
   assign scl_rise = scl_line & ~scl_q;
   // count restarts at every start, so a repeated start realigns the ack slot
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         sda_q <= 1'b1;
         scl_q <= 1'b1;
         in_frame <= 1'b0;
         bit_cnt <= 4'h0;
      end else begin
         sda_q <= sda_line;
         scl_q <= scl_line;
         in_frame <= start_seen | (in_frame & ~stop_seen);
         if (start_seen) begin
            bit_cnt <= 4'h0;
         end else if (scl_rise) begin
            bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
         end
      end
   end
   ////////////////////////////////////////
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);
   // no clock stretching, so the ack clock pulse follows within a bit period
   sequence s_ack_clock;
      ##[1:40] $rose(scl_line) ##[1:20] $fell(scl_line);
   endsequence
   property p_ack_hold;
      $rose(dev_sda_oe) |-> dev_sda_oe throughout s_ack_clock;
   endproperty
   a_ack_ninth_slot: assert property ($rose(dev_sda_oe) |-> bit_cnt == 4'h8 && in_frame)
      else $error("ack outside the ninth bit slot");
   a_dev_quiet_idle: assert property (!in_frame |-> !dev_sda_oe)
      else $error("device drives data outside a frame");
   a_clock_idle_free: assert property (!in_frame |-> !scl_oe)
      else $error("clock held low outside a frame");
   a_ack_host_off: assert property ($rose(dev_sda_oe) |-> !host_sda_oe)
      else $error("both ends drive data during ack");
   a_ack_held_long: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
      else $error("ack pulse too short");
   a_ack_spans_clock: assert property (p_ack_hold)
      else $error("ack not held through the ack clock");
   a_dev_change_low: assert property ($changed(dev_sda_oe) |-> !scl_line)
      else $error("device data changed while clock high");
   a_clock_high_width: assert property ($rose(scl_line) |-> scl_line [*7])
      else $error("clock high phase too short");
endmodule
`default_nettype wire

/* File: sim/oled_i2c_command_port_bench.sv */
`include "oic_defs.svh"
`default_nettype none
`define CHK(g, e) \
   begin \
      num_checks++; \
      if ((g) !== (e)) begin \
         failures++; \
         $display("[ERR] %0t got %h expected %h", $time, g, e); \
      end \
   end
module oled_i2c_command_port_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic CLK, SYS_RST, WR, RD, chk, pv, ADDR_SELECT_BIT, DRAIN_HOLD, PUMP_ON, REFERENCE_CURRENT_INT, DISPLAY_ON;
   logic rd_d = 1'b0;
   logic [3:0] ADDR;
   logic [31:0] WDATA, RDATA, pd, seed, ev, exp_q[$];
   logic [9:0] RD_ADDR;
   logic [7:0] RD_DATA, CONTRAST, MUX_RATIO, DISP_OFFSET, COM_CFG, rc, ro, bq[$], dv[4];
   logic [6:0] COL_PTR;
   logic [2:0] PAGE_PTR;
   int failures = 0;
   int num_checks = 0;
   oic_if link();
   oic_device #(.FIFO_DEPTH(4)) oic_device_inst (.CLK(CLK), .SYS_RST(SYS_RST), .LINK(link.device),
      .ADDR_SELECT_BIT(ADDR_SELECT_BIT), .DRAIN_HOLD(DRAIN_HOLD), .RD_ADDR(RD_ADDR),
      .RD_DATA(RD_DATA), .CONTRAST(CONTRAST), .MUX_RATIO(MUX_RATIO), .DISP_OFFSET(DISP_OFFSET),
      .PUMP_ON(PUMP_ON), .REFERENCE_CURRENT_INT(REFERENCE_CURRENT_INT), .COM_CFG(COM_CFG), .DISPLAY_ON(DISPLAY_ON),
      .COL_PTR(COL_PTR), .PAGE_PTR(PAGE_PTR));
   // short bit period keeps the run small
   oic_host #(.QUARTER_CYC(4)) oic_host_inst (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LINK(link.host));
   oic_link_properties props (.CLK(CLK), .SYS_RST(SYS_RST), .scl_oe(link.scl_oe),
      .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe), .scl_line(link.scl_line),
      .sda_line(link.sda_line));
   ////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic summarize();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
      @(posedge CLK);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      ADDR <= a;
      RD <= 1'b1;
      chk <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      @(posedge CLK);
   endtask
   task automatic probe(input logic [31:0] g, input logic [31:0] e);
      exp_q.push_back(e);
      pd <= g;
      pv <= 1'b1;
      @(posedge CLK);
      pv <= 1'b0;
      @(posedge CLK);
   endtask
   // status polls bypass the queue; only the nack bit is kept
   task automatic op(input logic [31:0] c, output logic nk);
      logic fin;
      fin = 1'b0;
      wr(`OIC_REG_CMD, c);
      for (int i = 0; i < 600 && !fin; i++) begin
         ADDR <= `OIC_REG_STATUS;
         RD <= 1'b1;
         chk <= 1'b0;
         @(posedge CLK);
         RD <= 1'b0;
         #1;
         nk = RDATA[1];
         fin = RDATA[0] === 1'b0;
         @(posedge CLK);
      end
      if (!fin) begin
         failures++;
         $display("[ERR] %0t host stayed busy", $time);
         summarize();
      end
   endtask
   // bytes at index na_from and later (address is 0) expect no ack
   task automatic frame(input logic sa, input logic rw, input int na_from);
      logic nk;
      op({28'h0, rw, sa, `OIC_OP_START}, nk);
      probe({31'h0, nk}, {31'h0, na_from <= 0});
      for (int k = 0; k < bq.size(); k++) begin
         wr(`OIC_REG_TXDATA, {24'h0, bq[k]});
         op({30'h0, `OIC_OP_WRITE}, nk);
         probe({31'h0, nk}, {31'h0, na_from <= k + 1});
      end
      op({30'h0, `OIC_OP_STOP}, nk);
   endtask
   ////////////////////////////////////////
   always @(posedge CLK) begin
      // take the note once: the compare macro names its expected value twice
      if ((rd_d || pv) && exp_q.size() > 0) begin
         ev = exp_q.pop_front();
         `CHK(rd_d ? RDATA : pd, ev)
      end
      rd_d <= RD & chk;
   end
   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end
   initial begin
      {SYS_RST, WR, RD, chk, pv} = 5'h10;
      {ADDR, WDATA, pd, RD_ADDR, ADDR_SELECT_BIT, DRAIN_HOLD} = '0;
      seed = 32'h0540E72C;
      repeat (12) @(posedge CLK);
      SYS_RST <= 1'b0;
      repeat (4) @(posedge CLK);
      probe({CONTRAST, MUX_RATIO, DISP_OFFSET, COM_CFG},
         {`OIC_CONTRAST_RST, `OIC_MUX_RST, `OIC_OFFSET_RST, `OIC_COMCFG_RST});
      probe({19'h0, PAGE_PTR, DISPLAY_ON, PUMP_ON, REFERENCE_CURRENT_INT, COL_PTR}, 32'h0);
      $display("test reset done");
      seed = lfsr(seed);
      rc = seed[7:0] | 8'h01;
      ro = {2'h0, seed[13:8]};
      // arguments that look like commands must be swallowed by their opcode
      bq = '{8'h00, 8'h81, rc, 8'hA8, 8'h1F, 8'hD3, ro, 8'h8D, 8'h14, 8'hAD, 8'h30, 8'hDA,
         8'h02, 8'hAF, 8'hD9, 8'hAE, 8'hDB, 8'hB5, 8'hD5, 8'hB6};
      frame(1'b0, 1'b0, 99);
      probe({CONTRAST, MUX_RATIO, DISP_OFFSET, COM_CFG}, {rc, 8'h1F, ro, 8'h02});
      probe({26'h0, PAGE_PTR, DISPLAY_ON, PUMP_ON, REFERENCE_CURRENT_INT}, 32'h7);
      $display("test command stream done");
      // decoder stalled: four bytes fit, the fifth is refused
      DRAIN_HOLD <= 1'b1;
      seed = lfsr(seed);
      dv = '{seed[7:0], 8'h80, seed[23:16], 8'hC0};
      bq = '{8'h40, dv[0], dv[1], dv[2], dv[3], 8'h5A};
      frame(1'b0, 1'b0, 6);
      probe({25'h0, COL_PTR}, 32'h0);
      DRAIN_HOLD <= 1'b0;
      repeat (10) @(posedge CLK);
      probe({25'h0, COL_PTR}, 32'h4);
      for (int i = 0; i < 4; i++) begin
         RD_ADDR <= 10'(i);
         repeat (2) @(posedge CLK);
         probe({24'h0, RD_DATA}, {24'h0, dv[i]});
      end
      $display("test data stream done");
      bq = '{8'h80, 8'h8D, 8'h80, 8'h10, 8'h80, 8'hAD, 8'h80, 8'h20, 8'hC0, 8'hA5, 8'h80, 8'hDA,
         8'h80, 8'h12, 8'h80, 8'hB2, 8'h80, 8'hAE};
      frame(1'b0, 1'b0, 99);
      probe({15'h0, PUMP_ON, REFERENCE_CURRENT_INT, COL_PTR, COM_CFG}, 32'h0512);
      RD_ADDR <= 10'h004;
      repeat (2) @(posedge CLK);
      probe({24'h0, RD_DATA}, 32'hA5);
      probe({28'h0, DISPLAY_ON, PAGE_PTR}, 32'h2);
      $display("test single control done");
      bq = '{8'h00, 8'h81, 8'h55};
      frame(1'b1, 1'b0, 0);
      probe({24'h0, CONTRAST}, {24'h0, rc});
      ADDR_SELECT_BIT <= 1'b1;
      repeat (4) @(posedge CLK);
      frame(1'b1, 1'b0, 99);
      probe({24'h0, CONTRAST}, 32'h55);
      $display("test address select done");
      bq = '{};
      frame(1'b1, 1'b1, 99);
      rd(4'hC, 32'h0);
      rd(`OIC_REG_TXDATA, 32'h55);
      $display("test read mode done");
      repeat (4) @(posedge CLK);
      summarize();
   end
endmodule
`default_nettype wire
